// File: hw/sbe_defs.svh
// Register offsets, field positions, reset values and counts for the SMBus byte engine
`ifndef SBE_DEFS_SVH
`define SBE_DEFS_SVH

`define SBE_ADDR_CTRL 8'hc0
`define SBE_ADDR_DATA 8'hc2
`define SBE_DATA_RST 8'h00
`define SBE_ZERO_BYTE 8'h00

`define SBE_BIT_SI 0
`define SBE_BIT_ACK 1
`define SBE_BIT_ARBITRATION_LOST_FLAG 2
`define SBE_BIT_RESPONSE_NEEDED_FLAG 3
`define SBE_BIT_STO 4
`define SBE_BIT_STA 5
`define SBE_BIT_TRANSMIT_DIRECTION_FLAG 6
`define SBE_BIT_MASTER 7

`define SBE_CNT_FIRST 3'h0
`define SBE_CNT_STEP 3'h1
`define SBE_BIT_LAST 3'h7
`define SBE_FREE_ZERO 4'h0
`define SBE_FREE_STEP 4'h1
`define SBE_FREE_TICKS 4'ha

`endif

// File: hw/sbe_pkg.sv
// Types shared by the SMBus byte engine
package sbe_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_HOLD,
    ST_BIT_LO,
    ST_BIT_HI,
    ST_ACK_LO,
    ST_ACK_HI,
    ST_STOP_LO,
    ST_STOP_HI,
    ST_STOP_END,
    ST_RS_LO,
    ST_RS_HI,
    ST_PASSIVE
  } sbe_state_t;

endpackage

// File: hw/sbe_sync.sv
// Two-flop synchroniser for the SCL and SDA pins
`timescale 1ns/100ps
`default_nettype none

module sbe_sync
  import sbe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_sync
);

  logic [1:0] meta_r;

  // Lines idle high, so reset to the released level
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 2'h3;
      pin_sync <= 2'h3;
    end
    else if (ce)
    begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: hw/sbe_cond_det.sv
// Bus condition detector: START, STOP, SCL rising edge, busy and free timeout
`timescale 1ns/100ps
`include "sbe_defs.svh"
`default_nettype none

module sbe_cond_det
  import sbe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic bit_tick,
  input wire logic free_to_en,
  output logic start_det,
  output logic stop_det,
  output logic scl_rise,
  output logic busy
);

  logic scl_prev_r;
  logic sda_prev_r;
  logic [3:0] free_cnt_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      start_det <= 1'b0;
      stop_det <= 1'b0;
      scl_rise <= 1'b0;
    end
    else if (ce)
    begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
      start_det <= scl_prev_r && scl_s && sda_prev_r && !sda_s;
      stop_det <= scl_prev_r && scl_s && !sda_prev_r && sda_s;
      scl_rise <= !scl_prev_r && scl_s;
    end
  end

  // Free timeout needs both lines high for more than the set number of clock source periods
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      free_cnt_r <= `SBE_FREE_ZERO;
    end
    else if (ce)
    begin
      if (start_det)
        busy <= 1'b1;
      else if (stop_det)
        busy <= 1'b0;
      else if (free_to_en && busy && scl_s && sda_s && bit_tick)
      begin
        if (free_cnt_r == `SBE_FREE_TICKS)
          busy <= 1'b0;
      end
      if (!(scl_s && sda_s) || !busy)
        free_cnt_r <= `SBE_FREE_ZERO;
      else if (bit_tick && free_cnt_r != `SBE_FREE_TICKS)
        free_cnt_r <= free_cnt_r + `SBE_FREE_STEP;
    end
  end

endmodule
`default_nettype wire

// File: hw/smbus_byte_engine.sv
// SMBus byte engine: status flags, data register, master transmit and receive
`timescale 1ns/100ps
`include "sbe_defs.svh"
`default_nettype none

module smbus_byte_engine
  import sbe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic smb_en,
  input wire logic free_to_en,
  input wire logic bit_tick,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_b,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  output logic bus_busy
);

  sbe_state_t state_r;
  sbe_state_t state_nxt;

  logic master_r;
  logic transmit_direction_flag_r;
  logic sta_r;
  logic sto_r;
  logic response_needed_flag_r;
  logic arbitration_lost_flag_r;
  logic ack_r;
  logic si_r;
  logic ack_written_r;
  logic data_written_r;
  logic addressed_r;
  logic from_start_r;
  logic [7:0] data_r;
  logic [2:0] bit_cnt_r;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic foreign_start;
  logic tick_hi;
  logic ack_eff;
  logic wr_ctrl;
  logic wr_data;
  logic scl_low;
  logic sda_low;

  logic ev_sgen;
  logic ev_lost;
  logic ev_lost_mid;
  logic ev_lost_stop;
  logic ev_si_only;
  logic ev_addr;
  logic ev_txack;
  logic ev_rxbyte;
  logic ev_ackdone;
  logic ev_stop_gen;
  logic ev_frame;
  logic shift_en;
  logic cnt_clr;
  logic cnt_inc;
  logic go_passive;

  function automatic logic sbe_is_last(input logic [2:0] cnt);
    sbe_is_last = (cnt == `SBE_BIT_LAST);
  endfunction

  sbe_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .pin_in({scl_i, sda_i}),
    .pin_sync(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  sbe_cond_det u_cond
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .bit_tick(bit_tick),
    .free_to_en(free_to_en),
    .start_det(start_det),
    .stop_det(stop_det),
    .scl_rise(scl_rise),
    .busy(bus_busy)
  );

  // Our own START shows up late through the synchroniser; SCL is held low in HOLD so none can be foreign
  assign foreign_start = start_det && (state_r != ST_START) && (state_r != ST_HOLD);
  // High phase only counts once SCL is really high, which honours clock stretching
  assign tick_hi = bit_tick && scl_s;
  assign ack_eff = ack_written_r && ack_r;
  assign wr_ctrl = sfr_wr && (sfr_addr == `SBE_ADDR_CTRL);
  assign wr_data = sfr_wr && (sfr_addr == `SBE_ADDR_DATA);

  always_comb
  begin
    state_nxt = state_r;
    ev_sgen = 1'b0;
    ev_lost = 1'b0;
    ev_lost_mid = 1'b0;
    ev_lost_stop = 1'b0;
    ev_si_only = 1'b0;
    ev_addr = 1'b0;
    ev_txack = 1'b0;
    ev_rxbyte = 1'b0;
    ev_ackdone = 1'b0;
    ev_stop_gen = 1'b0;
    ev_frame = 1'b0;
    shift_en = 1'b0;
    cnt_clr = 1'b0;
    cnt_inc = 1'b0;
    go_passive = 1'b0;
    if (!smb_en)
      state_nxt = ST_IDLE;
    else if (foreign_start && master_r && !sta_r)
    begin
      ev_lost = 1'b1;
      state_nxt = ST_IDLE;
    end
    else if (stop_det && master_r && state_r != ST_STOP_END)
    begin
      ev_lost = 1'b1;
      ev_lost_stop = 1'b1;
      state_nxt = ST_IDLE;
    end
    else if (stop_det && state_r == ST_PASSIVE)
      state_nxt = ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (foreign_start)
          begin
            go_passive = 1'b1;
            cnt_clr = 1'b1;
            state_nxt = ST_PASSIVE;
          end
          else if (sta_r && !bus_busy)
            state_nxt = ST_START;
        end
        ST_START:
        begin
          if (bit_tick)
          begin
            if (!scl_s)
            begin
              ev_lost = 1'b1;
              state_nxt = ST_IDLE;
            end
            else
            begin
              ev_sgen = 1'b1;
              state_nxt = ST_HOLD;
            end
          end
        end
        ST_HOLD:
        begin
          // Nothing moves on the bus until the event flag is cleared
          if (!si_r)
          begin
            if (!master_r)
              state_nxt = ST_IDLE;
            else if (response_needed_flag_r)
              state_nxt = ST_ACK_LO;
            else if (sto_r)
              state_nxt = ST_STOP_LO;
            else if (sta_r)
              state_nxt = ST_RS_LO;
            else
            begin
              ev_frame = 1'b1;
              cnt_clr = 1'b1;
              state_nxt = ST_BIT_LO;
            end
          end
        end
        ST_BIT_LO:
        begin
          if (bit_tick)
            state_nxt = ST_BIT_HI;
        end
        ST_BIT_HI:
        begin
          if (tick_hi)
          begin
            shift_en = 1'b1;
            if (transmit_direction_flag_r && data_r[7] && !sda_s)
            begin
              if (sbe_is_last(bit_cnt_r))
              begin
                ev_lost = 1'b1;
                state_nxt = ST_HOLD;
              end
              else
              begin
                // Keep sampling as a receiver so the register ends with the winner's byte
                ev_lost_mid = 1'b1;
                cnt_inc = 1'b1;
                state_nxt = ST_PASSIVE;
              end
            end
            else if (sbe_is_last(bit_cnt_r))
            begin
              if (transmit_direction_flag_r)
                state_nxt = ST_ACK_LO;
              else
              begin
                ev_rxbyte = 1'b1;
                state_nxt = ST_HOLD;
              end
            end
            else
            begin
              cnt_inc = 1'b1;
              state_nxt = ST_BIT_LO;
            end
          end
        end
        ST_ACK_LO:
        begin
          if (bit_tick)
            state_nxt = ST_ACK_HI;
        end
        ST_ACK_HI:
        begin
          if (tick_hi)
          begin
            if (response_needed_flag_r)
            begin
              ev_ackdone = 1'b1;
              if (sto_r)
                state_nxt = ST_STOP_LO;
              else if (sta_r)
                state_nxt = ST_RS_LO;
              else
              begin
                ev_frame = 1'b1;
                cnt_clr = 1'b1;
                state_nxt = ST_BIT_LO;
              end
            end
            else
            begin
              ev_txack = 1'b1;
              state_nxt = ST_HOLD;
            end
          end
        end
        ST_STOP_LO:
        begin
          if (bit_tick)
            state_nxt = ST_STOP_HI;
        end
        ST_STOP_HI:
        begin
          if (tick_hi)
            state_nxt = ST_STOP_END;
        end
        ST_STOP_END:
        begin
          if (bit_tick)
          begin
            if (!scl_s)
              ev_lost = 1'b1;
            else
              ev_stop_gen = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
        ST_RS_LO:
        begin
          if (bit_tick)
            state_nxt = ST_RS_HI;
        end
        ST_RS_HI:
        begin
          if (tick_hi)
            state_nxt = ST_START;
        end
        ST_PASSIVE:
        begin
          if (scl_rise)
          begin
            shift_en = 1'b1;
            if (sbe_is_last(bit_cnt_r))
            begin
              if (from_start_r)
                ev_addr = 1'b1;
              else
                ev_si_only = 1'b1;
              state_nxt = ST_HOLD;
            end
            else
              cnt_inc = 1'b1;
          end
        end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= `SBE_CNT_FIRST;
      from_start_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      if (cnt_clr)
        bit_cnt_r <= `SBE_CNT_FIRST;
      else if (cnt_inc)
        bit_cnt_r <= bit_cnt_r + `SBE_CNT_STEP;
      if (go_passive)
        from_start_r <= 1'b1;
      else if (ev_lost_mid)
        from_start_r <= 1'b0;
    end
  end

  // Software writes first; hardware events after, so a set in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      master_r <= 1'b0;
      transmit_direction_flag_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      response_needed_flag_r <= 1'b0;
      arbitration_lost_flag_r <= 1'b0;
      ack_r <= 1'b0;
      si_r <= 1'b0;
      ack_written_r <= 1'b0;
      data_written_r <= 1'b0;
      addressed_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        sta_r <= sfr_wdata[`SBE_BIT_STA];
        sto_r <= sfr_wdata[`SBE_BIT_STO];
        ack_r <= sfr_wdata[`SBE_BIT_ACK];
        if (response_needed_flag_r)
          ack_written_r <= 1'b1;
        if (!sfr_wdata[`SBE_BIT_SI])
        begin
          si_r <= 1'b0;
          arbitration_lost_flag_r <= 1'b0;
        end
      end
      if (wr_data)
      begin
        data_written_r <= 1'b1;
        transmit_direction_flag_r <= 1'b1;
      end
      if (ev_frame)
      begin
        transmit_direction_flag_r <= data_written_r;
        data_written_r <= 1'b0;
      end
      if (foreign_start)
      begin
        transmit_direction_flag_r <= 1'b0;
        addressed_r <= 1'b0;
      end
      if (stop_det && addressed_r)
      begin
        sto_r <= 1'b1;
        si_r <= 1'b1;
        addressed_r <= 1'b0;
      end
      if (ev_sgen)
      begin
        master_r <= 1'b1;
        transmit_direction_flag_r <= 1'b1;
        si_r <= 1'b1;
      end
      if (ev_lost || ev_lost_mid)
      begin
        master_r <= 1'b0;
        transmit_direction_flag_r <= 1'b0;
        arbitration_lost_flag_r <= 1'b1;
      end
      if (ev_lost || ev_si_only)
        si_r <= 1'b1;
      if (ev_lost_stop)
        sto_r <= 1'b1;
      if (ev_addr)
      begin
        sta_r <= 1'b1;
        si_r <= 1'b1;
        addressed_r <= 1'b1;
      end
      if (ev_txack)
      begin
        ack_r <= !sda_s;
        si_r <= 1'b1;
      end
      if (ev_rxbyte)
      begin
        response_needed_flag_r <= 1'b1;
        si_r <= 1'b1;
        ack_written_r <= 1'b0;
      end
      if (ev_ackdone)
        response_needed_flag_r <= 1'b0;
      if (ev_stop_gen)
      begin
        sto_r <= 1'b0;
        master_r <= 1'b0;
      end
    end
  end

  // Shift register is the data register itself; it only moves on sampled bits in ST_BIT_HI and ST_PASSIVE, never in ST_HOLD
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      data_r <= `SBE_DATA_RST;
    else if (ce)
    begin
      if (wr_data)
        data_r <= sfr_wdata;
      else if (shift_en)
        data_r <= {data_r[6:0], sda_s};
    end
  end

  always_comb
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    case (state_r)
      ST_START:
        sda_low = 1'b1;
      ST_HOLD:
      begin
        scl_low = 1'b1;
        sda_low = master_r && (!response_needed_flag_r || ack_eff);
      end
      ST_BIT_LO:
      begin
        scl_low = 1'b1;
        sda_low = transmit_direction_flag_r && !data_r[7];
      end
      ST_BIT_HI:
        sda_low = transmit_direction_flag_r && !data_r[7];
      ST_ACK_LO:
      begin
        scl_low = 1'b1;
        sda_low = response_needed_flag_r && ack_eff;
      end
      ST_ACK_HI:
        sda_low = response_needed_flag_r && ack_eff;
      ST_STOP_LO:
      begin
        scl_low = 1'b1;
        sda_low = 1'b1;
      end
      ST_STOP_HI:
        sda_low = 1'b1;
      ST_RS_LO:
        scl_low = 1'b1;
      default:
      begin
        scl_low = 1'b0;
        sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_oe_b <= 1'b1;
      sda_oe_b <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else if (ce)
    begin
      scl_oe_b <= !scl_low;
      sda_oe_b <= !sda_low;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sfr_rdata <= `SBE_ZERO_BYTE;
    else if (ce && sfr_rd)
    begin
      if (sfr_addr == `SBE_ADDR_CTRL)
        sfr_rdata <= {master_r, transmit_direction_flag_r, sta_r, sto_r, response_needed_flag_r, arbitration_lost_flag_r, ack_r, si_r};
      else if (sfr_addr == `SBE_ADDR_DATA)
        sfr_rdata <= data_r;
      else
        sfr_rdata <= `SBE_ZERO_BYTE;
    end
  end

endmodule
`default_nettype wire

// File: bench/sbe_asserts.sv
// Port-level checks for the SMBus byte engine
`timescale 1ns/100ps
`include "sbe_defs.svh"
`default_nettype none

module sbe_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic smb_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_b,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_b,
  input wire logic bus_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic rdc_r, ev_r, sta_r;
  wire logic wrc = ce & sfr_wr & (sfr_addr == `SBE_ADDR_CTRL);
  wire logic dat = sfr_addr == `SBE_ADDR_DATA;
  // Event is only known from a master status read, so own STOP events never count
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      rdc_r <= 1'b0;
      ev_r <= 1'b0;
      sta_r <= 1'b0;
    end
    else
    begin
      rdc_r <= ce & sfr_rd & (sfr_addr == `SBE_ADDR_CTRL);
      if (wrc)
        sta_r <= sfr_wdata[5];
      if ((wrc & !sfr_wdata[0]) | !smb_en)
        ev_r <= 1'b0;
      else if (rdc_r & sfr_rdata[0] & sfr_rdata[7])
        ev_r <= 1'b1;
    end
  a_stall_holds_scl: assert property (ev_r |-> !scl_oe_b)
    else $error("SCL released while event pending");
  a_rdata_holds: assert property (!$past(ce & sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_reads: assert property ($past(ce & sfr_rd & (sfr_addr != 8'hc0) & !dat) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_data_readback: assert property (sfr_wr & dat & ev_r ##1 !sfr_wr ##1 sfr_rd & dat |-> ##1 sfr_rdata == $past(sfr_wdata, 3))
    else $error("data byte changed while event set");
  a_begin_sticky: assert property (rdc_r & $past(sta_r) |-> sfr_rdata[5])
    else $error("begin flag cleared by hardware");
  a_open_drain: assert property (!scl_o & !sda_o)
    else $error("pin driven high");
  a_free_after_stop: assert property ($fell(bus_busy) |-> scl_i & sda_i)
    else $error("bus freed with a line low");
  a_start_synced: assert property ($rose(bus_busy) |-> !$past(sda_i, 2))
    else $error("busy rose before synchronised START");
  a_idle_after_reset: assert property (!$past(rst_b) |-> scl_oe_b & sda_oe_b & !bus_busy)
    else $error("lines not idle after reset");
endmodule

bind smbus_byte_engine sbe_asserts u_chk (
  .clk_sys, .rst_b, .ce, .smb_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .scl_i, .scl_o, .scl_oe_b, .sda_i, .sda_o, .sda_oe_b, .bus_busy
);
`default_nettype wire

// File: bench/sbe_slave_model.sv
// Behavioural SMBus slave on the far side of the byte engine
`timescale 1ns/100ps
`default_nettype none

module sbe_slave_model #(parameter logic [6:0] ADDR = 7'h2a) (
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  logic ack_q[$];
  logic [7:0] sh;
  logic [7:0] tb_b;
  logic act, adr, rd, nak;
  int n;
  int slow;
  initial
  begin
    {scl_pull, sda_pull, act, rd} = 4'h0;
    slow = 0;
  end
  // SCL may fall in the same time step as SDA moves, so look at it once both have settled
  always @(negedge sda)
  begin
    #1;
    if (scl)
    begin
      act = 1'b1;
      adr = 1'b1;
      nak = 1'b0;
      n = 0;
    end
  end
  always @(posedge sda)
  begin
    #1;
    if (scl)
      act = 1'b0;
  end
  always @(posedge scl)
    if (act)
    begin
      if (n < 8)
        sh = {sh[6:0], sda};
      else if (rd && !adr)
        ack_q.push_back(!sda);
      n++;
    end
  // SDA only moves well after SCL falls, so no false START or STOP is made
  always @(negedge scl)
    if (act)
    begin
      #10;
      if (n == 8 && adr)
      begin
        rd = sh[0];
        act = sh[7:1] == ADDR;
        sda_pull = act;
      end
      else if (n == 8)
      begin
        if (!rd)
          rx_q.push_back(sh);
        sda_pull = !rd;
      end
      else if (n == 9)
      begin
        if (rd && !adr && !ack_q[$])
          nak = 1'b1;
        adr = 1'b0;
        n = 0;
        sda_pull = 1'b0;
        if (rd && !nak)
        begin
          tb_b = tx_q.pop_front();
          sda_pull = !tb_b[7];
        end
        if (slow > 0)
        begin
          scl_pull = 1'b1;
          #(slow);
          scl_pull = 1'b0;
        end
      end
      else if (rd && !nak)
        sda_pull = !tb_b[7 - n];
    end
endmodule
`default_nettype wire

// File: bench/tb_smbus_byte_engine.sv
// Self-checking bench for the SMBus byte engine
`timescale 1ns/100ps
`include "sbe_defs.svh"
`default_nettype none

module tb_smbus_byte_engine;
  localparam logic [6:0] SLV = 7'h2a;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic bit_tick = 0;
  logic sfr_wr = 0;
  logic sfr_rd = 0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [2:0] tick_cnt = 3'h0;
  logic hold_scl = 1'b0;
  logic scl_o, scl_oe_b, sda_o, sda_oe_b, bus_busy, scl_pull, sda_pull;
  wire logic scl_w = scl_oe_b & !scl_pull & !hold_scl;
  wire logic sda_w = sda_oe_b & !sda_pull;
  int error_cnt = 0;
  int compares = 0;
  int i;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  logic [7:0] resp[3] = '{8'h02, 8'h00, 8'h10};

  smbus_byte_engine u_dut (
    .clk_sys, .rst_b, .ce(1'b1), .smb_en(1'b1), .free_to_en(1'b1), .bit_tick, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .scl_i(scl_w), .scl_o, .scl_oe_b,
    .sda_i(sda_w), .sda_o, .sda_oe_b, .bus_busy
  );
  sbe_slave_model #(.ADDR(SLV)) u_slv (.scl(scl_w), .sda(sda_w), .scl_pull, .sda_pull);

  always #2.5 clk_sys = ~clk_sys;
  // One half bit every eight system clocks
  always @(posedge clk_sys)
  begin
    tick_cnt <= tick_cnt + 3'h1;
    bit_tick <= tick_cnt == 3'h7;
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // A spare idle cycle keeps every strobe edge in its own time step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wev();
    int k;
    k = 0;
    v = 8'h00;
    while (v[0] !== 1'b1 && k < 500)
    begin
      acc(1'b0, `SBE_ADDR_CTRL, 8'h00);
      v = sfr_rdata;
      k++;
    end
    if (k == 500)
      chk("event wait", 8'h00, 8'h01);
  endtask

  task automatic wfree();
    int k;
    k = 0;
    while (bus_busy !== 1'b0 && k < 2000)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    acc(1'b0, `SBE_ADDR_CTRL, 8'h00);
    chk("stop status", sfr_rdata & 8'h90, 8'h00);
  endtask

  task automatic open_xfer(input logic [7:0] adb);
    acc(1'b1, `SBE_ADDR_CTRL, 8'h20);
    wev();
    chk("start status", v & 8'hfd, 8'he1);
    acc(1'b1, `SBE_ADDR_DATA, adb);
    acc(1'b0, `SBE_ADDR_DATA, 8'h00);
    chk("data readback", sfr_rdata, adb);
    acc(1'b1, `SBE_ADDR_CTRL, 8'h00);
    wev();
    acc(1'b0, `SBE_ADDR_DATA, 8'h00);
    chk("last bus byte", sfr_rdata, adb);
  endtask

  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hd6842d63));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    acc(1'b0, `SBE_ADDR_CTRL, 8'h00);
    chk("ctrl reset", sfr_rdata, 8'h00);
    acc(1'b0, `SBE_ADDR_DATA, 8'h00);
    chk("data reset", sfr_rdata, `SBE_DATA_RST);
    acc(1'b0, 8'hc1, 8'h00);
    chk("unmapped read", sfr_rdata, 8'h00);
    $display("test reset done");
    // Another device keeps SCL low, so every START attempt loses arbitration
    hold_scl <= 1'b1;
    @(posedge clk_sys);
    acc(1'b1, `SBE_ADDR_CTRL, 8'h20);
    wev();
    chk("start lost", v & 8'hfd, 8'h25);
    // A START attempt may still be pending after the first clear and lose once more
    acc(1'b1, `SBE_ADDR_CTRL, 8'h00);
    repeat (12) @(posedge clk_sys);
    acc(1'b1, `SBE_ADDR_CTRL, 8'h00);
    hold_scl <= 1'b0;
    acc(1'b0, `SBE_ADDR_CTRL, 8'h00);
    chk("lost cleared", sfr_rdata, 8'h00);
    $display("test arbitration done");
    // Slave stretches SCL after every acknowledge in this transfer
    u_slv.slow = 200;
    open_xfer({SLV, 1'b0});
    chk("address ack", v, 8'hc3);
    for (i = 0; i < 2; i++)
    begin
      exp_q.push_back(8'($urandom));
      acc(1'b1, `SBE_ADDR_DATA, exp_q[i]);
      acc(1'b1, `SBE_ADDR_CTRL, 8'h00);
      wev();
      chk("byte ack", v, 8'hc3);
    end
    acc(1'b1, `SBE_ADDR_CTRL, 8'h10);
    wfree();
    chk("slave count", 8'(u_slv.rx_q.size()), 8'h02);
    for (i = 0; i < 2; i++)
      chk("slave byte", u_slv.rx_q[i], exp_q[i]);
    $display("test write done");
    u_slv.slow = 0;
    open_xfer({~SLV, 1'b0});
    chk("address nack", v, 8'hc1);
    // Setting the begin flag as an active master gives a repeated START
    open_xfer({SLV, 1'b0});
    chk("restart ack", v, 8'hc3);
    acc(1'b1, `SBE_ADDR_CTRL, 8'h10);
    wfree();
    $display("test nack done");
    // Third byte follows a NACK, so the released line reads all ones
    exp_q.delete();
    for (i = 0; i < 2; i++)
    begin
      exp_q.push_back(8'($urandom));
      u_slv.tx_q.push_back(exp_q[i]);
    end
    exp_q.push_back(8'hff);
    open_xfer({SLV, 1'b1});
    chk("read address ack", v, 8'hc3);
    acc(1'b1, `SBE_ADDR_CTRL, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      wev();
      chk("rx status", v & 8'hfd, 8'h89);
      acc(1'b0, `SBE_ADDR_DATA, 8'h00);
      chk("rx byte", sfr_rdata, exp_q[i]);
      acc(1'b1, `SBE_ADDR_CTRL, resp[i]);
    end
    wfree();
    chk("ack count", 8'(u_slv.ack_q.size()), 8'h03);
    for (i = 0; i < 3; i++)
      chk("ack level", {7'h00, u_slv.ack_q[i]}, {7'h00, i == 0});
    $display("test read done");
    report_and_stop();
  end

  // Whole run needs well under a fifth of this span
  initial
  begin
    #(100000);
    error_cnt++;
    $display("ERROR watchdog expected done seen hang");
    report_and_stop();
  end
endmodule
`default_nettype wire
